// File: pkg/tdp_defs.vh
// Functional notes
// R1: Each timer underflow triggers one DMA copy of one table byte to port; code holds one pending trigger, later underflows are dropped until it starts.
// R2: On underflow the timer reloads from its reload value and keeps counting.
// R3: Interval event repeats every (reload value + 1) count clocks.
// R4: Eight independent 16-bit timer channels; any one selects the DMA trigger.
// R5: PWM frequency is one over interval period times table length.
// R6: Table depth matches resolution, 256 entries for 8 bits, one per interval.
// R7: Bit n of each transferred byte drives port pin n.
// R8: All eight outputs change together on one common time base.
// R9: After the last entry the DMA raises an end-of-transfers interrupt.
// R10: Processor reloads the transfer counter on the end-of-transfers interrupt.
// R11: Software sets a channel bit in entries 0..N and clears the rest.
// R12: DMA and processor share one bus; the DMA wins arbitration.
// R13: Software programs source, destination and mode before starting transfers.
// R14: Choose the underflow rate so the processor keeps enough bus bandwidth.
// R15: Each transfer takes two clocks and stalls the processor throughout.
// R16: Counter decrements per transfer, readable, locked while active, max 1024.
// R17: Source address advances one byte per transfer; destination stays fixed.
`ifndef TDP_DEFS_VH
`define TDP_DEFS_VH
`define TDP_NCH        8
`define TDP_TW         16
`define TDP_SEL_W      3
`define TDP_DW         8
`define TDP_AW         10
`define TDP_DEPTH      1024
`define TDP_CW         11
`define TDP_CNT_MAX    11'h400
`define TDP_CNT_ZERO   11'h000
`define TDP_CNT_ONE    11'h001
`define TDP_ADDR_ONE   10'h001
`define TDP_TMR_ZERO   16'h0000
`define TDP_TMR_ONE    16'h0001
`define TDP_BCNT_W     2
`define TDP_BUF_FULL   2'h2
`define TDP_BCNT_ZERO  2'h0
`define TDP_BCNT_ONE   2'h1
`define TDP_PORT_RST   8'h00
`endif

// File: hw/tdp_table_ram.v
`timescale 1ns/1ns
`include "tdp_defs.vh"

module tdp_table_ram (
    input  wire                  clk_sys,
    input  wire                  we,
    input  wire [`TDP_AW-1:0]    addr,
    input  wire [`TDP_DW-1:0]    wdata,
    output reg  [`TDP_DW-1:0]    rdata_q
);
    reg [`TDP_DW-1:0] mem [0:`TDP_DEPTH-1];

    always @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule // tdp_table_ram

// File: hw/tdp_pwm_top.v
`timescale 1ns/1ns
`include "tdp_defs.vh"

module tdp_pwm_top (
    input  wire                          clk_sys,
    input  wire                          rst_n,
    input  wire [`TDP_NCH*`TDP_TW-1:0]   timer_reload_value,
    input  wire [`TDP_NCH-1:0]           timer_enable,
    input  wire [`TDP_SEL_W-1:0]         trig_sel,
    output wire [`TDP_NCH-1:0]           timer_interval_event,
    input  wire                          cpu_req,
    input  wire                          cpu_we,
    input  wire [`TDP_AW-1:0]            cpu_addr,
    input  wire [`TDP_DW-1:0]            cpu_wdata,
    output wire                          cpu_stall,
    output reg                           cpu_rvalid_q,
    output wire [`TDP_DW-1:0]            cpu_rdata,
    input  wire                          dma_start,
    input  wire [`TDP_AW-1:0]            dma_src_base,
    input  wire [`TDP_CW-1:0]            dma_count_load,
    output reg                           dma_active_q,
    output wire [`TDP_CW-1:0]            transfer_counter,
    output reg                           dma_end_irq_q,
    input  wire                          port_accept,
    output wire [`TDP_DW-1:0]            pwm_output_port
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WR   = 1'b1;

    // Interval timer array: eight down counters with auto reload
    // Counters clear to zero, so an enabled channel fires right after reset
    reg  [`TDP_TW-1:0] tcnt_q [0:`TDP_NCH-1];
    reg  [`TDP_NCH-1:0] tev_q;
    genvar g;
    generate
        for (g = 0; g < `TDP_NCH; g = g + 1) begin : g_tmr
            wire [`TDP_TW-1:0] rld = timer_reload_value[g*`TDP_TW +: `TDP_TW];
            reg  [`TDP_TW-1:0] tcnt_d;
            reg                tev_d;
            // A stopped channel sits at its reload value and stays quiet
            always @* begin
                tcnt_d = tcnt_q[g] - `TDP_TMR_ONE;
                tev_d  = 1'b0;
                if (!timer_enable[g]) begin
                    tcnt_d = rld;
                end else if (tcnt_q[g] == `TDP_TMR_ZERO) begin
                    tcnt_d = rld; // see R2
                    tev_d  = 1'b1; // see R3
                end
            end
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    tcnt_q[g] <= `TDP_TMR_ZERO;
                    tev_q[g]  <= 1'b0;
                end else begin
                    tcnt_q[g] <= tcnt_d;
                    tev_q[g]  <= tev_d;
                end
            end
        end
    endgenerate
    assign timer_interval_event = tev_q; // see R4

    // Port-side acceptance comes from outside and is synchronised
    reg acc_s1_q;
    reg acc_s2_q;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_s1_q <= 1'b0;
            acc_s2_q <= 1'b0;
        end else begin
            acc_s1_q <= port_accept;
            acc_s2_q <= acc_s1_q;
        end
    end

    // Two-entry buffer between table read and output port
    reg  [`TDP_DW-1:0]     buf_q [0:1];
    reg                    buf_wp_q;
    reg                    buf_rp_q;
    reg  [`TDP_BCNT_W-1:0] buf_cnt_q;
    wire                   buf_in_ready = (buf_cnt_q != `TDP_BUF_FULL);
    wire                   buf_out_valid = (buf_cnt_q != `TDP_BCNT_ZERO);
    wire                   buf_pop = buf_out_valid & acc_s2_q;
    wire                   buf_push;
    reg  [`TDP_BCNT_W-1:0] buf_cnt_d;
    reg  [`TDP_DW-1:0]     port_q;

    // DMA channel
    reg                 st_q;
    reg                 pend_q;
    reg [`TDP_AW-1:0]   src_q;
    reg [`TDP_CW-1:0]   xfer_cnt_q;
    wire                trig = tev_q[trig_sel]; // see R1
    wire                dma_go = (st_q == ST_IDLE) & dma_active_q &
                                 pend_q & buf_in_ready;
    wire [`TDP_DW-1:0]  ram_rdata;
    assign buf_push = (st_q == ST_WR);

    // DMA owns the bus during both transfer cycles
    wire dma_bus = dma_go | (st_q == ST_WR); // see R12
    assign cpu_stall = cpu_req & dma_bus; // see R15
    wire cpu_grant = cpu_req & ~dma_bus;
    // The processor writes the table only in a cycle it was granted
    wire               ram_we = cpu_grant & cpu_we;
    wire [`TDP_AW-1:0] ram_addr = dma_bus ? src_q : cpu_addr;
    assign cpu_rdata = ram_rdata;

    tdp_table_ram u_ram (
        .clk_sys (clk_sys),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (cpu_wdata),
        .rdata_q (ram_rdata)
    );

    // A load is refused while active, for a zero count or above the limit
    wire load_ok = dma_start & ~dma_active_q &
                   (dma_count_load != `TDP_CNT_ZERO) &
                   (dma_count_load <= `TDP_CNT_MAX); // see R16
    wire last_wr = (st_q == ST_WR) & (xfer_cnt_q == `TDP_CNT_ONE);

    // Next values of the DMA channel registers
    reg                 st_d;
    reg                 pend_d;
    reg [`TDP_AW-1:0]   src_d;
    reg                 act_d;
    reg [`TDP_CW-1:0]   xfer_cnt_d;
    always @* begin
        st_d       = st_q;
        pend_d     = pend_q;
        src_d      = src_q;
        act_d      = dma_active_q;
        xfer_cnt_d = xfer_cnt_q;
        // A new trigger wins over the clear by the transfer start
        if (trig & dma_active_q) begin
            pend_d = 1'b1;
        end else if (dma_go) begin
            pend_d = 1'b0;
        end
        case (st_q)
            ST_IDLE: begin
                if (dma_go) begin
                    st_d = ST_WR; // see R15
                end
            end
            ST_WR: begin
                // One table entry per transfer, started by one pending trigger
                st_d       = ST_IDLE;
                src_d      = src_q + `TDP_ADDR_ONE; // see R5, see R17
                xfer_cnt_d = xfer_cnt_q - `TDP_CNT_ONE; // see R16
                if (last_wr) begin
                    act_d = 1'b0; // see R9
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // Counter and source are only loaded while transfers are stopped
        if (load_ok) begin
            xfer_cnt_d = dma_count_load; // see R6
            src_d      = dma_src_base;
            act_d      = 1'b1;
            pend_d     = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q          <= ST_IDLE;
            pend_q        <= 1'b0;
            src_q         <= {`TDP_AW{1'b0}};
            dma_active_q  <= 1'b0;
            xfer_cnt_q    <= `TDP_CNT_ZERO;
            dma_end_irq_q <= 1'b0;
            cpu_rvalid_q  <= 1'b0;
        end else begin
            st_q          <= st_d;
            pend_q        <= pend_d;
            src_q         <= src_d;
            dma_active_q  <= act_d;
            xfer_cnt_q    <= xfer_cnt_d;
            dma_end_irq_q <= last_wr; // see R9
            cpu_rvalid_q  <= cpu_grant & ~cpu_we;
        end
    end
    assign transfer_counter = xfer_cnt_q;

    // Slot count: a push and a pop in one cycle cancel out
    always @* begin
        buf_cnt_d = buf_cnt_q;
        if (buf_push & ~buf_pop) begin
            buf_cnt_d = buf_cnt_q + `TDP_BCNT_ONE;
        end else if (buf_pop & ~buf_push) begin
            buf_cnt_d = buf_cnt_q - `TDP_BCNT_ONE;
        end
    end

    // Buffer storage and output port register
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            buf_wp_q  <= 1'b0;
            buf_rp_q  <= 1'b0;
            buf_cnt_q <= `TDP_BCNT_ZERO;
            buf_q[0]  <= `TDP_PORT_RST;
            buf_q[1]  <= `TDP_PORT_RST;
            port_q    <= `TDP_PORT_RST;
        end else begin
            if (buf_push) begin
                buf_q[buf_wp_q] <= ram_rdata;
                buf_wp_q        <= ~buf_wp_q;
            end
            if (buf_pop) begin
                // Whole byte at once: all pins share one update edge
                port_q   <= buf_q[buf_rp_q]; // see R7, see R8
                buf_rp_q <= ~buf_rp_q;
            end
            buf_cnt_q <= buf_cnt_d;
        end
    end
    assign pwm_output_port = port_q;
endmodule // tdp_pwm_top

// File: tb/tdp_pwm_top_properties.sv
`timescale 1ns/1ns
`include "tdp_defs.vh"
module tdp_pwm_props (
    input wire                clk_sys,
    input wire                rst_n,
    input wire [`TDP_NCH-1:0] timer_interval_event,
    input wire                cpu_req,
    input wire                cpu_we,
    input wire                cpu_stall,
    input wire                cpu_rvalid_q,
    input wire                dma_active_q,
    input wire [`TDP_CW-1:0]  transfer_counter,
    input wire                dma_end_irq_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire ev0 = timer_interval_event[0];
    wire ev1 = timer_interval_event[1];
    ev_period_a: assert property (ev0 |=> !ev0 [*4] ##1 ev0)
        else $error("channel 0 period wrong");
    ev_pulse_a: assert property (ev1 |=> !ev1)
        else $error("channel 1 event too long");
    irq_pulse_a: assert property (dma_end_irq_q |=> !dma_end_irq_q)
        else $error("end pulse too long");
    irq_end_a: assert property (dma_end_irq_q |-> !dma_active_q &&
        transfer_counter == `TDP_CNT_ZERO) else $error("end pulse early");
    irq_fall_a: assert property ($fell(dma_active_q) |-> dma_end_irq_q)
        else $error("silent end");
    cnt_step_a: assert property ($changed(transfer_counter) &&
        $past(dma_active_q) |-> transfer_counter ==
        $past(transfer_counter) - `TDP_CNT_ONE) else $error("bad decrement");
    cnt_space_a: assert property ($changed(transfer_counter) &&
        $past(dma_active_q) |=> $stable(transfer_counter))
        else $error("transfers too close");
    stall_own_a: assert property (cpu_stall |-> dma_active_q)
        else $error("stall while idle");
    rd_ans_a: assert property (cpu_req && !cpu_we && !cpu_stall
        |=> cpu_rvalid_q) else $error("read not answered");
    cover property (dma_end_irq_q);
    cover property (cpu_req && cpu_stall);
    cover property (cpu_rvalid_q);
endmodule // tdp_pwm_props

// File: tb/tdp_load_model.sv
`timescale 1ns/1ns
module tdp_load_model (
    input  wire clk_sys,
    input  wire hold_off,
    output reg  port_accept
);
    initial port_accept = 1'b0;
    always @(posedge clk_sys) port_accept <= !hold_off;
endmodule // tdp_load_model

// File: tb/table_driven_port_pwm_bench.sv
`timescale 1ns/1ns
`include "tdp_defs.vh"
module table_driven_port_pwm_bench;
    reg                         clk_sys = 1'b0;
    reg                         rst_n = 1'b0;
    reg  [`TDP_NCH*`TDP_TW-1:0] timer_reload_value = {112'h0, 32'h00060004};
    reg  [`TDP_NCH-1:0]         timer_enable = 8'h03;
    reg  [`TDP_SEL_W-1:0]       trig_sel = 3'h0;
    reg                         cpu_req = 1'b0;
    reg                         cpu_we = 1'b0;
    reg  [`TDP_AW-1:0]          cpu_addr = 10'h000;
    reg  [`TDP_DW-1:0]          cpu_wdata = 8'h00;
    reg                         dma_start = 1'b0;
    reg  [`TDP_AW-1:0]          dma_src_base = 10'h010;
    reg  [`TDP_CW-1:0]          dma_count_load = 11'h004;
    reg                         hold_off = 1'b1;
    wire [`TDP_NCH-1:0]         timer_interval_event;
    wire                        cpu_stall, cpu_rvalid_q, dma_active_q;
    wire                        dma_end_irq_q, port_accept;
    wire [`TDP_DW-1:0]          cpu_rdata, pwm_output_port;
    wire [`TDP_CW-1:0]          transfer_counter;
    integer                     err_total = 0, checked = 0, cyc = 0;
    integer                     irqs = 0, i, n;
    reg  [7:0]                  tbl [0:3];
    tdp_pwm_top dut_u (
        .clk_sys              (clk_sys),
        .rst_n                (rst_n),
        .timer_reload_value   (timer_reload_value),
        .timer_enable         (timer_enable),
        .trig_sel             (trig_sel),
        .timer_interval_event (timer_interval_event),
        .cpu_req              (cpu_req),
        .cpu_we               (cpu_we),
        .cpu_addr             (cpu_addr),
        .cpu_wdata            (cpu_wdata),
        .cpu_stall            (cpu_stall),
        .cpu_rvalid_q         (cpu_rvalid_q),
        .cpu_rdata            (cpu_rdata),
        .dma_start            (dma_start),
        .dma_src_base         (dma_src_base),
        .dma_count_load       (dma_count_load),
        .dma_active_q         (dma_active_q),
        .transfer_counter     (transfer_counter),
        .dma_end_irq_q        (dma_end_irq_q),
        .port_accept          (port_accept),
        .pwm_output_port      (pwm_output_port)
    );
    tdp_load_model load_u (
        .clk_sys     (clk_sys),
        .hold_off    (hold_off),
        .port_accept (port_accept)
    );
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (dma_end_irq_q === 1'b1) irqs <= irqs + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    task stop_test;
        begin
            $display("mismatches %0d checks %0d", err_total, checked);
            if (err_total == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // Holds the request until an edge where the bus is free
    task cpu(input w, input [9:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            cpu_req <= 1'b1;
            cpu_we <= w;
            cpu_addr <= a;
            cpu_wdata <= d;
            n = 0;
            @(negedge clk_sys);
            while (cpu_stall !== 1'b0 && n < 50) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            chk("stall", 0, cpu_stall);
            @(posedge clk_sys);
            cpu_req <= 1'b0;
            @(negedge clk_sys);
        end
    endtask
    task go(input [10:0] c);
        begin
            @(posedge clk_sys);
            dma_count_load <= c;
            dma_start <= 1'b1;
            @(posedge clk_sys);
            dma_start <= 1'b0;
        end
    endtask
    task port_is(input [7:0] e);
        reg [7:0] last;
        begin
            last = pwm_output_port;
            n = 0;
            while (pwm_output_port === last && n < 200) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            chk("port", e, pwm_output_port);
        end
    endtask
    task t_timer(input integer c, input integer p);
        begin
            n = 0;
            while (timer_interval_event[c] !== 1'b1 && n < 99) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            n = 0;
            do begin
                @(negedge clk_sys);
                n = n + 1;
            end while (timer_interval_event[c] !== 1'b1 && n < 99);
            chk("period", p, n);
            $display("t_timer %0d done", c);
        end
    endtask
    task t_dma;
        begin
            for (i = 0; i < 4; i = i + 1)
                cpu(1'b1, 10'h010 + i, tbl[i]);
            cpu(1'b0, 10'h012, 8'h00);
            chk("rdata", tbl[2], cpu_rdata);
            go(11'h004);
            repeat (40) @(negedge clk_sys);
            chk("count", 11'h002, transfer_counter);
            @(posedge clk_sys);
            hold_off <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
                port_is(tbl[i]);
            chk("irqs", 1, irqs);
            chk("count", 0, transfer_counter);
            go(11'h004);
            port_is(tbl[0]);
            for (i = 0; i < 5; i = i + 1) begin
                cpu(1'b0, 10'h013, 8'h00);
                chk("busrd", tbl[3], cpu_rdata);
            end
            $display("t_dma done");
        end
    endtask
    task t_refuse;
        begin
            repeat (60) @(posedge clk_sys);
            trig_sel <= 3'h1;
            go(11'h004);
            port_is(tbl[0]);
            n = 0;
            while (pwm_output_port === tbl[0] && n < 50) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            chk("spacing", 7, n);
            chk("port", tbl[1], pwm_output_port);
            repeat (30) @(posedge clk_sys);
            chk("irqs", 3, irqs);
            for (i = 0; i < 2; i = i + 1) begin
                go(i ? 11'h401 : 11'h000);
                repeat (12) @(negedge clk_sys);
                chk("active", 0, dma_active_q);
            end
            $display("t_refuse done");
        end
    endtask
    initial begin
        tbl[0] = 8'hff;
        tbl[1] = 8'hee;
        tbl[2] = 8'hcc;
        tbl[3] = 8'h88;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_timer(0, 5);
        t_timer(1, 7);
        t_dma;
        t_refuse;
        stop_test;
    end
endmodule // table_driven_port_pwm_bench
bind tdp_pwm_top tdp_pwm_props chk_u (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .timer_interval_event (timer_interval_event),
    .cpu_req              (cpu_req),
    .cpu_we               (cpu_we),
    .cpu_stall            (cpu_stall),
    .cpu_rvalid_q         (cpu_rvalid_q),
    .dma_active_q         (dma_active_q),
    .transfer_counter     (transfer_counter),
    .dma_end_irq_q        (dma_end_irq_q)
);
